// file: rtl/rllm_consts.svh
// constants of the receiver loss and lock monitor: offsets, fields, reset values, counts
`ifndef RLLM_CONSTS_SVH
`define RLLM_CONSTS_SVH

// register byte addresses on the 8-bit local address
`define RLLM_ADDR_W 8
`define RLLM_ADDR_CTRL 8'h00
`define RLLM_ADDR_STATUS 8'h04

// control register fields
`define RLLM_CTRL_ANA_DIS 0
`define RLLM_CTRL_DIG_DIS 1
`define RLLM_CTRL_THR_SEL 2
`define RLLM_CTRL_EQ_GAIN 3
`define RLLM_CTRL_EQ_BYP 4
`define RLLM_CTRL_MUTE 5
`define RLLM_CTRL_RATE_LO 6
`define RLLM_CTRL_RATE_HI 7
`define RLLM_CTRL_RESET 8'h00

// status register fields
`define RLLM_STAT_LOCK_LOSS 0
`define RLLM_STAT_DIG_LOSS 1
`define RLLM_STAT_ANA_LOSS 2
`define RLLM_STAT_COMB_LOSS 3

// bus responses
`define RLLM_RESP_OKAY 2'h0
`define RLLM_RESP_SLVERR 2'h2

// digital loss counts in line symbols
`define RLLM_DS3_DECL 8'haf
`define RLLM_DS3_WIN 8'haf
`define RLLM_DS3_ONES 8'h3a
`define RLLM_E3_DECL 8'h20
`define RLLM_E3_WIN 8'h20
`define RLLM_E3_ONES 8'h0b
`define RLLM_ZRUN_MAX 8'hff

// lock window: reference edges per window and accepted line edge range (0.5 %)
`define RLLM_LOCK_LAST 10'h3ff
`define RLLM_LOCK_MIN 11'h3fb
`define RLLM_LOCK_MAX 11'h405
`define RLLM_LINE_MAX 11'h7ff

`endif

// file: rtl/rllm_pkg.sv
// types shared by the receiver loss and lock monitor
package rllm_pkg;
	typedef enum logic [1:0] {
		RLLM_RATE_DS3,
		RLLM_RATE_STS1,
		RLLM_RATE_E3
	} rllm_rate_e;

	typedef enum logic {
		RLLM_DIG_CLEAR,
		RLLM_DIG_DECLARED
	} rllm_dig_e;
endpackage

// file: rtl/rllm_sync.sv
// two-flop synchronisers with rising edge detect, one per bit
`timescale 1ns/1ns
module rllm_sync #(
	parameter int W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out,
	output logic [W-1:0] rise_out
);
	////////////////////////////////////////////////////////////////////////
	// first stage feeds only the second; edge logic looks at stages two and three
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg, s2_reg, s3_reg;
			logic s1_next, s2_next, s3_next;
			always_comb begin
				s1_next = async_in[i];
				s2_next = s1_reg;
				s3_next = s2_reg;
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
				end else begin
					s1_reg <= s1_next;
					s2_reg <= s2_next;
					s3_reg <= s3_next;
				end
			end
			assign sync_out[i] = s2_reg;
			assign rise_out[i] = s2_reg & ~s3_reg;
		end
	endgenerate
endmodule

// file: rtl/rllm_axil.sv
// axi4-lite slave holding the control register and reading back status
`timescale 1ns/1ns
`include "rllm_consts.svh"
module rllm_axil import rllm_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`RLLM_ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [`RLLM_ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic [3:0] status_in,
	output logic [7:0] ctrl_out
);
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [`RLLM_ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [7:0] wbyte_reg, wbyte_next, ctrl_reg, ctrl_next;
	logic wstrb0_reg, wstrb0_next;
	logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	////////////////////////////////////////////////////////////////////////
	// address and data are caught independently; the write lands once both are held
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wbyte_next = wbyte_reg;
		wstrb0_next = wstrb0_reg;
		ctrl_next = ctrl_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			awaddr_next = s_awaddr;
		end
		if (s_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wbyte_next = s_wdata[7:0];
			wstrb0_next = s_wstrb[0];
		end
		if (bvalid_reg && s_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_held_reg && w_held_reg && !bvalid_reg) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `RLLM_RESP_OKAY;
			if (awaddr_reg == `RLLM_ADDR_CTRL) begin
				if (wstrb0_reg) begin
					ctrl_next = wbyte_reg;
				end
			end else if (awaddr_reg != `RLLM_ADDR_STATUS) begin
				bresp_next = `RLLM_RESP_SLVERR;
			end
		end
		// reads answer on the edge that takes the address
		if (rvalid_reg && s_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = `RLLM_RESP_OKAY;
			rdata_next = 32'h0000_0000;
			if (s_araddr == `RLLM_ADDR_CTRL) begin
				rdata_next = {24'h00_0000, ctrl_reg};
			end else if (s_araddr == `RLLM_ADDR_STATUS) begin
				rdata_next = {28'h000_0000, status_in};
			end else begin
				rresp_next = `RLLM_RESP_SLVERR;
			end
		end
		awready_next = !aw_held_next && !bvalid_next;
		wready_next = !w_held_next && !bvalid_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wbyte_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			ctrl_reg <= `RLLM_CTRL_RESET;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RLLM_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `RLLM_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wbyte_reg <= wbyte_next;
			wstrb0_reg <= wstrb0_next;
			ctrl_reg <= ctrl_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
		end
	end

	assign s_awready = awready_reg;
	assign s_wready = wready_reg;
	assign s_bvalid = bvalid_reg;
	assign s_bresp = bresp_reg;
	assign s_arready = arready_reg;
	assign s_rvalid = rvalid_reg;
	assign s_rresp = rresp_reg;
	assign s_rdata = rdata_reg;
	assign ctrl_out = ctrl_reg;
endmodule

// file: rtl/rllm_top.sv
// receiver loss-of-signal and lock monitor for one line channel
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`include "rllm_consts.svh"
module rllm_top import rllm_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`RLLM_ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [`RLLM_ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic line_clock,
	input wire logic line_input_positive,
	input wire logic line_input_negative,
	input wire logic channel_reference_clock,
	input wire logic analog_level_low,
	input wire logic analog_level_restored,
	output logic recovered_clock_out,
	output logic receive_data_positive,
	output logic receive_data_negative,
	output logic lock_loss_flag,
	output logic digital_signal_loss_flag,
	output logic analog_signal_loss_flag,
	output logic combined_signal_loss_flag,
	output logic equalizer_bypass,
	output logic equalizer_gain_enable,
	output logic loss_threshold_select,
	output logic [1:0] line_rate_select
);
	logic [5:0] sync_lvl, sync_rise;
	logic [7:0] ctrl;
	logic line_s, line_rise, ref_s, ref_rise, pos_s, neg_s, low_s, high_s;
	logic ana_dis, dig_dis, mute, is_e3, zero_sym;
	logic [7:0] decl_len, win_len, ones_need;
	rllm_dig_e dig_reg, dig_next;
	logic [7:0] zrun_reg, zrun_next, win_reg, win_next, ones_reg, ones_next;
	logic [7:0] win_inc, ones_inc;
	logic alos_reg, alos_next;
	logic [9:0] refcnt_reg, refcnt_next;
	logic [10:0] linecnt_reg, linecnt_next;
	logic lock_ok_reg, lock_ok_next, comb_loss, lock_loss;
	logic clk_out_reg, clk_out_next, dpos_reg, dpos_next, dneg_reg, dneg_next;
	logic lol_reg, comb_reg;

	////////////////////////////////////////////////////////////////////////
	// pins from the line side and the analog comparators cross into aclk here
	rllm_sync #(.W(6)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({analog_level_restored, analog_level_low, line_input_negative,
			line_input_positive, channel_reference_clock, line_clock}),
		.sync_out(sync_lvl),
		.rise_out(sync_rise)
	);

	rllm_axil u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.status_in({comb_reg, alos_reg, dig_reg == RLLM_DIG_DECLARED, lol_reg}),
		.ctrl_out(ctrl)
	);

	assign line_s = sync_lvl[0];
	assign line_rise = sync_rise[0];
	assign ref_s = sync_lvl[1];
	assign ref_rise = sync_rise[1];
	assign pos_s = sync_lvl[2];
	assign neg_s = sync_lvl[3];
	assign low_s = sync_lvl[4];
	assign high_s = sync_lvl[5];
	assign ana_dis = ctrl[`RLLM_CTRL_ANA_DIS];
	assign dig_dis = ctrl[`RLLM_CTRL_DIG_DIS];
	assign mute = ctrl[`RLLM_CTRL_MUTE];
	assign is_e3 = ctrl[`RLLM_CTRL_RATE_HI:`RLLM_CTRL_RATE_LO] == RLLM_RATE_E3;
	assign zero_sym = !pos_s && !neg_s;

	////////////////////////////////////////////////////////////////////////
	// digital loss: counts chosen by rate; an unused rate code acts as DS3
	always_comb begin
		decl_len = is_e3 ? `RLLM_E3_DECL : `RLLM_DS3_DECL;
		win_len = is_e3 ? `RLLM_E3_WIN : `RLLM_DS3_WIN;
		ones_need = is_e3 ? `RLLM_E3_ONES : `RLLM_DS3_ONES;
		win_inc = 8'(win_reg + 8'h01);
		ones_inc = 8'(ones_reg + {7'h00, !zero_sym});
		dig_next = dig_reg;
		zrun_next = zrun_reg;
		win_next = win_reg;
		ones_next = ones_reg;
		if (line_rise) begin
			if (!zero_sym) begin
				zrun_next = 8'h00;
			end else if (zrun_reg != `RLLM_ZRUN_MAX) begin
				zrun_next = 8'(zrun_reg + 8'h01);
			end
		end
		case (dig_reg)
			RLLM_DIG_CLEAR: begin
				if (line_rise && zero_sym && (8'(zrun_reg + 8'h01) >= decl_len)) begin
					dig_next = RLLM_DIG_DECLARED;
					win_next = 8'h00;
					ones_next = 8'h00;
				end
			end
			RLLM_DIG_DECLARED: begin
				if (line_rise) begin
					win_next = win_inc;
					ones_next = ones_inc;
					if (win_inc == win_len) begin
						// density tested over whole windows only, so clearing is never early
						win_next = 8'h00;
						ones_next = 8'h00;
						if (ones_inc >= ones_need) begin
							dig_next = RLLM_DIG_CLEAR;
						end
					end
				end
			end
			default: dig_next = RLLM_DIG_CLEAR;
		endcase
		if (dig_dis) begin
			dig_next = RLLM_DIG_CLEAR;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog loss follows the comparators; a low level wins over a restore
	always_comb begin
		alos_next = alos_reg;
		if (ana_dis) begin
			alos_next = 1'b0;
		end else if (low_s) begin
			alos_next = 1'b1;
		end else if (high_s) begin
			alos_next = 1'b0;
		end
		comb_loss = (dig_next == RLLM_DIG_DECLARED) || alos_next;
	end

	////////////////////////////////////////////////////////////////////////
	// lock: line edges counted across 1024 reference edges must sit within 0.5 %
	always_comb begin
		refcnt_next = refcnt_reg;
		linecnt_next = linecnt_reg;
		lock_ok_next = lock_ok_reg;
		if (line_rise && linecnt_reg != `RLLM_LINE_MAX) begin
			linecnt_next = 11'(linecnt_reg + 11'h001);
		end
		if (ref_rise) begin
			refcnt_next = 10'(refcnt_reg + 10'h001);
			if (refcnt_reg == `RLLM_LOCK_LAST) begin
				lock_ok_next = (linecnt_reg >= `RLLM_LOCK_MIN) &&
					(linecnt_reg <= `RLLM_LOCK_MAX);
				linecnt_next = {10'h000, line_rise};
			end
		end
		lock_loss = !lock_ok_next || comb_loss;
	end

	////////////////////////////////////////////////////////////////////////
	// output pins; the clock output is resampled, so it carries one aclk of jitter
	always_comb begin
		clk_out_next = lock_loss ? ref_s : line_s;
		dpos_next = dpos_reg;
		dneg_next = dneg_reg;
		if (mute && comb_loss) begin
			dpos_next = 1'b0;
			dneg_next = 1'b0;
		end else if (line_rise) begin
			dpos_next = pos_s;
			dneg_next = neg_s;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dig_reg <= RLLM_DIG_CLEAR;
			zrun_reg <= 8'h00;
			win_reg <= 8'h00;
			ones_reg <= 8'h00;
			alos_reg <= 1'b0;
			refcnt_reg <= 10'h000;
			linecnt_reg <= 11'h000;
			lock_ok_reg <= 1'b0;
			clk_out_reg <= 1'b0;
			dpos_reg <= 1'b0;
			dneg_reg <= 1'b0;
			lol_reg <= 1'b1;
			comb_reg <= 1'b0;
		end else begin
			dig_reg <= dig_next;
			zrun_reg <= zrun_next;
			win_reg <= win_next;
			ones_reg <= ones_next;
			alos_reg <= alos_next;
			refcnt_reg <= refcnt_next;
			linecnt_reg <= linecnt_next;
			lock_ok_reg <= lock_ok_next;
			clk_out_reg <= clk_out_next;
			dpos_reg <= dpos_next;
			dneg_reg <= dneg_next;
			lol_reg <= lock_loss;
			comb_reg <= comb_loss;
		end
	end

	assign recovered_clock_out = clk_out_reg;
	assign receive_data_positive = dpos_reg;
	assign receive_data_negative = dneg_reg;
	assign lock_loss_flag = lol_reg;
	assign digital_signal_loss_flag = dig_reg == RLLM_DIG_DECLARED;
	assign analog_signal_loss_flag = alos_reg;
	assign combined_signal_loss_flag = comb_reg;
	assign equalizer_bypass = ctrl[`RLLM_CTRL_EQ_BYP];
	assign equalizer_gain_enable = ctrl[`RLLM_CTRL_EQ_GAIN];
	assign loss_threshold_select = ctrl[`RLLM_CTRL_THR_SEL];
	assign line_rate_select = ctrl[`RLLM_CTRL_RATE_HI:`RLLM_CTRL_RATE_LO];

	////////////////////////////////////////////////////////////////////////
	// checks and coverage
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_clk_recovered: assert property (!lock_loss |=> recovered_clock_out == $past(line_s))
		else $error("clock output not recovered clock while locked");
	chk_clk_reference: assert property (lock_loss |=> recovered_clock_out == $past(ref_s))
		else $error("clock output not reference clock during lock loss");
	chk_lol_on_loss: assert property (combined_signal_loss_flag |-> lock_loss_flag)
		else $error("signal loss without lock loss");
	chk_ds3_declare: assert property (!is_e3 && !dig_dis && line_rise && zero_sym &&
		zrun_reg == 8'hae |=> digital_signal_loss_flag)
		else $error("no digital loss after 175 zeros");
	chk_e3_declare: assert property (is_e3 && !dig_dis && line_rise && zero_sym &&
		zrun_reg == 8'h1f ##1 !dig_dis |-> digital_signal_loss_flag)
		else $error("no e3 loss after 32 zeros");
	chk_no_early_clear: assert property (digital_signal_loss_flag && !dig_dis &&
		!(line_rise && win_inc == win_len) |=> digital_signal_loss_flag)
		else $error("digital loss cleared outside window end");
	chk_zrun_restart: assert property (line_rise && !zero_sym |=> zrun_reg == 8'h00)
		else $error("zero run not restarted by pulse");
	chk_rlos_or: assert property (combined_signal_loss_flag ==
		(digital_signal_loss_flag || analog_signal_loss_flag))
		else $error("combined loss is not the or of both");
	chk_alos_declare: assert property (!ana_dis && low_s |=> analog_signal_loss_flag)
		else $error("analog loss not declared on low level");
	// the disables may drop on the next edge, so only the cycle after they are seen is judged
	chk_los_disabled: assert property (ana_dis && dig_dis |=>
		!combined_signal_loss_flag && !digital_signal_loss_flag &&
		!analog_signal_loss_flag)
		else $error("loss seen with detection disabled");
	chk_mute_data: assert property (mute && comb_loss |=>
		!receive_data_positive && !receive_data_negative)
		else $error("data not muted during loss");

	cov_dig_declare: cover property (dig_reg == RLLM_DIG_CLEAR ##1 dig_reg == RLLM_DIG_DECLARED);
	cov_dig_clear: cover property (dig_reg == RLLM_DIG_DECLARED ##1 dig_reg == RLLM_DIG_CLEAR);
	cov_lock_gain: cover property (lock_loss_flag ##1 !lock_loss_flag);
	cov_mute: cover property (mute && comb_reg);
endmodule

// file: sim/rllm_line_model.sv
// line side model: line clock, symbol rails and free reference clock
`timescale 1ns/1ns
module rllm_line_model (
	output logic line_clock,
	output logic line_input_positive,
	output logic line_input_negative,
	output logic channel_reference_clock
);
	////////////////////////////////////////////////////////////////////////
	// the reference runs free; the line clock runs only while symbols flow
	initial begin
		line_clock = 1'b0;
		line_input_positive = 1'b0;
		line_input_negative = 1'b0;
		channel_reference_clock = 1'b0;
		forever #40 channel_reference_clock = ~channel_reference_clock;
	end
	////////////////////////////////////////////////////////////////////////
	// rails settle half a period before the strobing rise
	task automatic send(input logic p, input logic n, input int cnt);
		#3;
		for (int i = 0; i < cnt; i++) begin
			line_input_positive = p;
			line_input_negative = n;
			#40 line_clock = 1'b1;
			#40 line_clock = 1'b0;
		end
		// stale rails flip so a stopped line never passes for held data
		line_input_positive = ~p;
		line_input_negative = ~n;
	endtask
endmodule

// file: sim/rllm_top_test.sv
// self-checking bench of the receiver loss and lock monitor
`timescale 1ns/1ns
`include "rllm_consts.svh"
module rllm_top_test import rllm_pkg::*;;
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, line_rate_select;
	logic line_clock, line_input_positive, line_input_negative, channel_reference_clock;
	logic analog_level_low, analog_level_restored, recovered_clock_out;
	logic receive_data_positive, receive_data_negative, lock_loss_flag;
	logic digital_signal_loss_flag, analog_signal_loss_flag, combined_signal_loss_flag;
	logic equalizer_bypass, equalizer_gain_enable, loss_threshold_select;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	////////////////////////////////////////////////////////////////////////
	// design and line partner
	rllm_top dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
		.s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .line_clock,
		.line_input_positive, .line_input_negative, .channel_reference_clock,
		.analog_level_low, .analog_level_restored, .recovered_clock_out,
		.receive_data_positive, .receive_data_negative, .lock_loss_flag,
		.digital_signal_loss_flag, .analog_signal_loss_flag, .combined_signal_loss_flag,
		.equalizer_bypass, .equalizer_gain_enable, .loss_threshold_select,
		.line_rate_select);
	rllm_line_model lm (.line_clock, .line_input_positive, .line_input_negative,
		.channel_reference_clock);
	////////////////////////////////////////////////////////////////////////
	// clock and hang guard, ceiling well above the longest sequence
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			miscompares++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_awready === 1'b1) begin
				ad = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!wd && s_wready === 1'b1) begin
				wd = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
		chk("bresp", er, s_bresp);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		do @(posedge aclk); while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
		chk("rresp", er, s_rresp);
		chk("rdata", ed, s_rdata);
	endtask
	// cycles with the clock output high over a span
	task automatic hicnt(input int span, output int n);
		n = 0;
		repeat (span) begin
			@(posedge aclk);
			n += (recovered_clock_out === 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk("lock", 1'h1, lock_loss_flag);
		chk("comb", 1'h0, combined_signal_loss_flag);
		axr(`RLLM_ADDR_CTRL, 32'h0, `RLLM_RESP_OKAY);
		axr(`RLLM_ADDR_STATUS, 32'h1, `RLLM_RESP_OKAY);
		axw(`RLLM_ADDR_STATUS, 32'hf, `RLLM_RESP_OKAY);
		axr(`RLLM_ADDR_STATUS, 32'h1, `RLLM_RESP_OKAY);
		axw(8'h10, 32'h0, `RLLM_RESP_SLVERR);
		axr(8'h10, 32'h0, `RLLM_RESP_SLVERR);
		$display("test reset done");
	endtask
	task automatic t_ctrl();
		for (int r = 0; r < 3; r++) begin
			axw(`RLLM_ADDR_CTRL, {r[1:0], 6'h1c}, `RLLM_RESP_OKAY);
			wt(2);
			chk("bypass", 1'h1, equalizer_bypass);
			chk("gain", 1'h1, equalizer_gain_enable);
			chk("thr", 1'h1, loss_threshold_select);
			chk("rate", r[1:0], line_rate_select);
			axr(`RLLM_ADDR_CTRL, {r[1:0], 6'h1c}, `RLLM_RESP_OKAY);
		end
		axw(`RLLM_ADDR_CTRL, 32'h0, `RLLM_RESP_OKAY);
		$display("test control done");
	endtask
	task automatic t_lock();
		int n;
		lm.send(1'b1, 1'b0, 2600);
		wt(3);
		chk("locked", 1'h0, lock_loss_flag);
		hicnt(16, n);
		chk("line clock out", 32'h0, n);
		for (int i = 0; i < 25000 && lock_loss_flag !== 1'b1; i++) @(posedge aclk);
		chk("unlock", 1'h1, lock_loss_flag);
		axr(`RLLM_ADDR_STATUS, 32'h1, `RLLM_RESP_OKAY);
		hicnt(40, n);
		chk("ref clock out", 1'h1, n > 10 && n < 30);
		$display("test lock done");
	endtask
	task automatic t_ds3();
		lm.send(1'b0, 1'b0, 174);
		wt(6);
		chk("dig", 1'h0, digital_signal_loss_flag);
		lm.send(1'b1, 1'b0, 1);
		lm.send(1'b0, 1'b0, 174);
		wt(6);
		chk("dig", 1'h0, digital_signal_loss_flag);
		lm.send(1'b0, 1'b0, 1);
		wt(6);
		chk("dig", 1'h1, digital_signal_loss_flag);
		chk("comb", 1'h1, combined_signal_loss_flag);
		axr(`RLLM_ADDR_STATUS, 32'hb, `RLLM_RESP_OKAY);
		axw(`RLLM_ADDR_CTRL, 32'h20, `RLLM_RESP_OKAY);
		lm.send(1'b1, 1'b0, 57);
		wt(4);
		chk("muted", 1'h0, receive_data_positive);
		chk("muted n", 1'h0, receive_data_negative);
		lm.send(1'b0, 1'b0, 118);
		wt(6);
		chk("dig", 1'h1, digital_signal_loss_flag);
		lm.send(1'b1, 1'b0, 175);
		wt(6);
		chk("dig", 1'h0, digital_signal_loss_flag);
		chk("comb", 1'h0, combined_signal_loss_flag);
		lm.send(1'b1, 1'b0, 1);
		wt(4);
		chk("data", 1'h1, receive_data_positive);
		lm.send(1'b0, 1'b1, 1);
		wt(4);
		chk("data n", 1'h1, receive_data_negative);
		axw(`RLLM_ADDR_CTRL, 32'h0, `RLLM_RESP_OKAY);
		$display("test ds3 done");
	endtask
	task automatic t_ana();
		@(posedge aclk);
		analog_level_low <= 1'b1;
		analog_level_restored <= 1'b0;
		wt(6);
		chk("ana", 1'h1, analog_signal_loss_flag);
		chk("comb", 1'h1, combined_signal_loss_flag);
		axr(`RLLM_ADDR_STATUS, 32'hd, `RLLM_RESP_OKAY);
		axw(`RLLM_ADDR_CTRL, 32'h3, `RLLM_RESP_OKAY);
		wt(3);
		chk("ana", 1'h0, analog_signal_loss_flag);
		chk("comb", 1'h0, combined_signal_loss_flag);
		axw(`RLLM_ADDR_CTRL, 32'h0, `RLLM_RESP_OKAY);
		analog_level_low <= 1'b0;
		analog_level_restored <= 1'b1;
		wt(6);
		chk("ana", 1'h0, analog_signal_loss_flag);
		$display("test analog done");
	endtask
	task automatic t_e3();
		// square e3 pulses on a short cable: software bypasses the equalizer
		axw(`RLLM_ADDR_CTRL, 32'h90, `RLLM_RESP_OKAY);
		chk("e3 bypass", 1'h1, equalizer_bypass);
		lm.send(1'b0, 1'b0, 31);
		wt(6);
		chk("e3 dig", 1'h0, digital_signal_loss_flag);
		lm.send(1'b0, 1'b0, 1);
		wt(6);
		chk("e3 dig", 1'h1, digital_signal_loss_flag);
		lm.send(1'b1, 1'b0, 32);
		wt(6);
		chk("e3 dig", 1'h0, digital_signal_loss_flag);
		$display("test e3 done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// verdict and main sequence
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		s_awaddr = 8'h00;
		s_araddr = 8'h00;
		s_wdata = 32'h0;
		s_wstrb = 4'hf;
		analog_level_low = 1'b0;
		analog_level_restored = 1'b1;
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_lock();
		t_ds3();
		t_ana();
		t_e3();
		summarize();
	end
endmodule
